/* hw/timer0_core.sv */
// 8-bit timer/counter with shared prescaler and register port
// Operation
// - Source select clear gives timer mode, one step per instruction cycle unscaled.
// - A count write blocks counting for the next two instruction cycles.
// - Source select set gives counter mode, stepping on count pin edges.
// - Edge select zero counts rising pin edges, one counts falling edges.
// - Assignment bit routes the one prescaler to timer (0) or watchdog (1).
// - Prescaler is 8 bits, ratio 1:2 to 1:256 for the timer.
// - With timer assignment, any count register write zeroes the prescaler.
// - With watchdog assignment, the watchdog clear zeroes the prescaler.
// - Software cannot write the prescaler count; with timer assignment status bit 0 reads its sampled tap.
// - Every reset leaves the prescaler at zero.
// - Counter mode samples the pin, or the prescaler output when scaled, on phases Q2 and Q4.
// - Scaled counter mode divides the pin before the phase sampling.
// - Count steps three to seven cycles after an input change.
// - Source select set forces the count pin to input direction.
// - Count register is 8-bit read/write at 01h, kept across reset.
// - Assignment and ratio may change any time without stopping the count.
`timescale 1ns/1ps
module timer0_core import timer0_pkg::*; (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic count_pin_i,
    input wire logic watchdog_clear_i,
    input wire logic watchdog_tick_i,
    output logic watchdog_post_o,
    output logic [3:0] pin_direction_o
);
    // ========================================
    // Helper functions
    // Mask of the low stages that must be full before a watchdog tick passes
    function automatic logic [7:0] ratio_mask(input logic [2:0] r);
        logic [7:0] m;
        m = 8'h01 << r;
        return m - 8'h01;
    endfunction

    // Address match for a strobe
    function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
        return stb && (a == ofs);
    endfunction

    // ========================================
    // Declarations
    presc_if ps ();
    logic [7:0] timer_count_r;
    logic [7:0] timer_config_r;
    logic [3:0] pin_direction_r;
    logic [7:0] rdata_r;
    logic [3:0] dir_out_r;
    logic post_pulse_r;
    phase_type phase_r;
    logic [1:0] inhibit_r;
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic filt_r;
    logic filt_nxt;
    logic pin_prev_r;
    logic samp_r;
    logic count_wr;
    logic config_wr;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assignment;
    logic [2:0] prescale_ratio;
    logic pin_level;
    logic pin_rise;
    logic instr_end;
    logic sample_phase;
    logic src_level;
    logic sample_rise;
    logic step;

    // ========================================
    // Register decode
    assign count_wr = hit(reg_wr_i, reg_addr_i, TIMER_COUNT_OFS);
    assign config_wr = hit(reg_wr_i, reg_addr_i, TIMER_CONFIG_OFS);
    assign clock_source_select = timer_config_r[CLOCK_SOURCE_SELECT_BIT];
    assign source_edge_select = timer_config_r[SOURCE_EDGE_SELECT_BIT];
    assign prescaler_assignment = timer_config_r[PRESCALER_ASSIGNMENT_BIT];
    assign prescale_ratio = timer_config_r[PRESCALE_RATIO_LSB +: PRESCALE_RATIO_W];

    // Configuration: write-only, takes effect on the next edge with the count running
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            timer_config_r <= TIMER_CONFIG_RST;
        end else if (config_wr) begin
            timer_config_r <= reg_wdata_i;
        end
    end

    // Pin direction latch, all inputs after reset
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pin_direction_r <= PIN_DIRECTION_RST;
        end else if (hit(reg_wr_i, reg_addr_i, PIN_DIRECTION_OFS)) begin
            pin_direction_r <= reg_wdata_i[3:0];
        end
    end

    // Counter mode overrides the count pin to an input
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            dir_out_r <= PIN_DIRECTION_RST;
        end else begin
            dir_out_r <= pin_direction_r;
            dir_out_r[COUNT_PIN] <= pin_direction_r[COUNT_PIN] | clock_source_select;
        end
    end
    assign pin_direction_o = dir_out_r;

    // Read port; prescaler has no address, but under timer assignment status bit 0 holds its sampled tap
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rdata_r <= 8'h00;
        end else if (hit(reg_rd_i, reg_addr_i, TIMER_COUNT_OFS)) begin
            rdata_r <= timer_count_r;
        end else if (hit(reg_rd_i, reg_addr_i, TIMER_STATUS_OFS)) begin
            rdata_r <= {5'h00, inhibit_r, samp_r};
        end else begin
            rdata_r <= 8'h00;
        end
    end
    assign reg_rdata_o = rdata_r;

    // ========================================
    // Phase generator: four clocks per instruction cycle
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            phase_r <= PHASE_Q1;
        end else begin
            case (phase_r)
                PHASE_Q1: phase_r <= PHASE_Q2;
                PHASE_Q2: phase_r <= PHASE_Q3;
                PHASE_Q3: phase_r <= PHASE_Q4;
                PHASE_Q4: phase_r <= PHASE_Q1;
                default: phase_r <= PHASE_Q1;
            endcase
        end
    end
    assign instr_end = (phase_r == PHASE_Q4);
    assign sample_phase = (phase_r == PHASE_Q2) || (phase_r == PHASE_Q4);

    // ========================================
    // Count pin synchroniser; a level counts once stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
        end else begin
            sync1_r <= count_pin_i;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Pulses shorter than two cycles may be missed here
    assign filt_nxt = (sync2_r == sync3_r) ? sync3_r : filt_r;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            filt_r <= 1'b0;
            pin_prev_r <= 1'b1; // Seen high, so reset never fakes a pin rise
        end else begin
            filt_r <= filt_nxt;
            pin_prev_r <= pin_level;
        end
    end

    // Falling-edge mode inverts the pin so one rise detector serves both
    assign pin_level = filt_r ^ source_edge_select;
    assign pin_rise = pin_level && !pin_prev_r;

    // ========================================
    // Prescaler routing: watchdog ticks, pin edges or instruction cycles
    assign ps.clear = (count_wr && !prescaler_assignment)
        || (watchdog_clear_i && prescaler_assignment);
    assign ps.step = prescaler_assignment ? watchdog_tick_i
        : (clock_source_select ? pin_rise : instr_end);
    assign ps.ratio = prescale_ratio;

    shared_prescaler #(
        .CNT_W(PRESC_W)
    ) u_presc (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .ps(ps)
    );

    // Postscaled watchdog tick, silent while the timer owns the prescaler
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            post_pulse_r <= 1'b0;
        end else begin
            post_pulse_r <= prescaler_assignment && watchdog_tick_i && !watchdog_clear_i
                && ((ps.count & ratio_mask(prescale_ratio)) == ratio_mask(prescale_ratio));
        end
    end
    assign watchdog_post_o = post_pulse_r;

    // ========================================
    // Phase sampling of the source; unscaled counter mode sees the pin itself
    assign src_level = prescaler_assignment ? pin_level : ps.tap;
    assign sample_rise = sample_phase && src_level && !samp_r;

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            samp_r <= 1'b1; // Idle pin in falling mode must not count as a rise
        end else if (sample_phase) begin
            samp_r <= src_level;
        end
    end

    // ========================================
    // Write inhibit: two full instruction-cycle ends before counting again
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            inhibit_r <= 2'h0;
        end else if (count_wr) begin
            inhibit_r <= INHIBIT_CYCLES;
        end else if (instr_end && inhibit_r != 2'h0) begin
            inhibit_r <= inhibit_r - 2'h1;
        end
    end

    // Unscaled timer mode steps on each cycle end, all else on sampled rises
    assign step = !count_wr && (inhibit_r == 2'h0)
        && ((!clock_source_select && prescaler_assignment) ? instr_end
        : sample_rise);

    // Count register: no reset, its value survives device resets
    always_ff @(posedge core_clk_i) begin
        if (count_wr) begin
            timer_count_r <= reg_wdata_i;
        end else if (step) begin
            timer_count_r <= timer_count_r + 8'h01;
        end
    end

    // ========================================
    // Checks
    inhibit_load_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        count_wr |=> inhibit_r == INHIBIT_CYCLES)
        else $error("inhibit not loaded by count write");

    inhibit_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (inhibit_r != 2'h0) && !count_wr |=> $stable(timer_count_r))
        else $error("count moved during write inhibit");

    timer_step_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !clock_source_select && prescaler_assignment && instr_end && inhibit_r == 2'h0 && !count_wr
        |=> timer_count_r == $past(timer_count_r) + 8'h01)
        else $error("timer mode missed its cycle step");

    phase_sample_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clock_source_select && step |-> sample_phase)
        else $error("counter mode stepped off a sample phase");

    pin_delay_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clock_source_select && prescaler_assignment && $rose(pin_level) && !samp_r
        && inhibit_r == 2'h0 && !count_wr |-> ##[0:1] sample_rise)
        else $error("pin edge not sampled in time");

    presc_write_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        count_wr && !prescaler_assignment |=> ps.count == PRESC_RST)
        else $error("count write left prescaler set");

    presc_watchdog_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        watchdog_clear_i && prescaler_assignment |=> ps.count == PRESC_RST)
        else $error("watchdog clear left prescaler set");

    presc_owner_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        prescaler_assignment && !watchdog_tick_i && !watchdog_clear_i && !config_wr
        |=> $stable(ps.count))
        else $error("prescaler moved without a watchdog tick");

    dir_override_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clock_source_select |=> pin_direction_o[COUNT_PIN])
        else $error("count pin not forced to input");

    count_wrap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        step && timer_count_r == 8'hff |=> timer_count_r == 8'h00)
        else $error("count did not wrap to zero");
endmodule // timer0_core

/* shared/timer0_pkg.sv */
// Constants and types shared by the timer/counter and its prescaler
package timer0_pkg;
    // ========================================
    // Register offsets
    localparam logic [7:0] TIMER_COUNT_OFS = 8'h01;
    localparam logic [7:0] TIMER_CONFIG_OFS = 8'h10;
    localparam logic [7:0] PIN_DIRECTION_OFS = 8'h11;
    localparam logic [7:0] TIMER_STATUS_OFS = 8'h12;
    // ========================================
    // Configuration field positions
    localparam int CLOCK_SOURCE_SELECT_BIT = 5;
    localparam int SOURCE_EDGE_SELECT_BIT = 4;
    localparam int PRESCALER_ASSIGNMENT_BIT = 3;
    localparam int PRESCALE_RATIO_LSB = 0;
    localparam int PRESCALE_RATIO_W = 3;
    // ========================================
    // Reset values and sizes
    localparam logic [7:0] TIMER_CONFIG_RST = 8'hff;
    localparam logic [3:0] PIN_DIRECTION_RST = 4'hf;
    localparam int COUNT_PIN = 2;
    localparam int PRESC_W = 8;
    localparam logic [7:0] PRESC_RST = 8'h00;
    // ========================================
    // Timing: inhibit in instruction cycles, delays in clock cycles (one oscillator period)
    localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
    localparam int INCR_DELAY_MIN_TOSC = 3;
    localparam int INCR_DELAY_MAX_TOSC = 7;
    // Four phases make one instruction cycle
    typedef enum logic [1:0] {
        PHASE_Q1 = 2'b00,
        PHASE_Q2 = 2'b01,
        PHASE_Q3 = 2'b10,
        PHASE_Q4 = 2'b11
    } phase_type;
endpackage

/* shared/presc_if.sv */
// Carrier between the timer core and the shared prescaler
`timescale 1ns/1ps
interface presc_if;
    import timer0_pkg::*;
    logic clear;
    logic step;
    logic [PRESCALE_RATIO_W-1:0] ratio;
    logic [PRESC_W-1:0] count;
    logic tap;
    modport core (output clear, output step, output ratio, input count, input tap);
    modport scaler (input clear, input step, input ratio, output count, output tap);
endinterface

/* hw/shared_prescaler.sv */
// Shared 8-bit prescaler counter with ratio tap
`timescale 1ns/1ps
module shared_prescaler import timer0_pkg::*; #(
    parameter int CNT_W = PRESC_W
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    presc_if.scaler ps
);
    // ========================================
    // Elaboration check
    // The tap select covers eight stages, so a narrower counter cannot serve
    if (CNT_W != PRESC_W) begin : g_width_check
        $error("shared_prescaler: CNT_W must equal PRESC_W");
    end

    logic [CNT_W-1:0] cnt_r;

    // ========================================
    // Counter: reset and clear win over a step
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            cnt_r <= PRESC_RST;
        end else if (ps.clear) begin
            cnt_r <= PRESC_RST;
        end else if (ps.step) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Ratio picks a ripple stage; each stage output is a square wave
    assign ps.count = cnt_r;
    assign ps.tap = cnt_r[ps.ratio];

    presc_reset_a: assert property (@(posedge core_clk_i) !reset_n_i |=> cnt_r == PRESC_RST)
        else $error("prescaler not zero after reset");
endmodule // shared_prescaler

/* verif/count_source.sv */
// Model of the external source that drives the count pin
`timescale 1ns/1ps
module count_source (
    input wire logic core_clk_i,
    input wire logic go_i,
    input wire logic [3:0] half_i,
    input wire logic [7:0] pulses_i,
    output logic count_pin_o,
    output logic busy_o
);
    // ========================================
    // Pulse train, high level first, idle low
    int left = 0;
    int tick = 0;
    int half = 2;
    initial begin
        count_pin_o = 1'b0;
        busy_o = 1'b0;
    end
    // Levels never shorter than two clocks, or the phase sampler could miss one
    always @(posedge core_clk_i) begin
        if (!busy_o && go_i && pulses_i != 8'h00) begin
            half = (half_i < 4'h2) ? 2 : int'(half_i);
            left = 2 * int'(pulses_i) - 1;
            tick = 1;
            busy_o <= 1'b1;
            count_pin_o <= 1'b1;
        end else if (busy_o && tick < half) begin
            tick = tick + 1;
        end else if (busy_o) begin
            tick = 1;
            left = left - 1;
            count_pin_o <= ~count_pin_o;
            busy_o <= (left != 0);
        end
    end
endmodule // count_source

/* verif/tb.sv */
// Self-checking bench for the timer/counter with shared prescaler
`timescale 1ns/1ps
module tb import timer0_pkg::*;;
    // ========================================
    // Stimulus and observation signals
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic wd_clr = 1'b0;
    logic wd_tick = 1'b0;
    logic go = 1'b0;
    logic [3:0] half = 4'h2;
    logic [7:0] pulses = 8'h00;
    logic [7:0] rdata;
    logic [3:0] pin_dir;
    logic pin;
    logic wd_post;
    logic busy;
    logic [7:0] x;
    logic [7:0] a1;
    logic [7:0] a2;
    int n_errors = 0;
    int n_checks = 0;
    int n_post = 0;
    int seed = 32'hd0b1;
    int p0;
    int n;

    timer0_core uut (.core_clk_i(core_clk), .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .count_pin_i(pin), .watchdog_clear_i(wd_clr),
        .watchdog_tick_i(wd_tick), .watchdog_post_o(wd_post), .pin_direction_o(pin_dir));
    count_source src (.core_clk_i(core_clk), .go_i(go), .half_i(half), .pulses_i(pulses),
        .count_pin_o(pin), .busy_o(busy));

    // ========================================
    // Clock, post pulse tally
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) if (wd_post === 1'b1) n_post <= n_post + 1;

    // ========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Direction output is registered, so look at it mid-cycle once it has settled
    task automatic chk_dir(input logic [3:0] exp);
        @(negedge core_clk);
        chk("pin_dir", {4'h0, exp}, {4'h0, pin_dir});
        @(posedge core_clk);
    endtask
    // One bus cycle, then one idle edge so strobes never change twice at once
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge core_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
        @(posedge core_clk);
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd8(input logic [7:0] a, output logic [7:0] d);
        bus(1'b0, a, 8'h00, d);
    endtask
    task automatic wd_pulse(input logic c, input int gap);
        if (c) wd_clr <= 1'b1;
        else wd_tick <= 1'b1;
        @(posedge core_clk);
        wd_clr <= 1'b0;
        wd_tick <= 1'b0;
        repeat (gap) @(posedge core_clk);
    endtask
    task automatic burst(input logic [3:0] h, input int cnt);
        half <= h;
        pulses <= 8'(cnt);
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ========================================
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("[FAIL] run expected end seen timeout");
        report_and_stop;
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        // Registers, write-only reads and direction override; the count powers up unknown
        wreg(TIMER_COUNT_OFS, 8'h00);
        chk_dir(4'hf);
        wreg(PIN_DIRECTION_OFS, 8'h00);
        chk_dir(4'h4);
        rd8(TIMER_CONFIG_OFS, a1);
        chk("config_read", 8'h00, a1);
        rd8({1'b1, 7'($random(seed))}, a1);
        chk("unmapped", 8'h00, a1);
        $display("test registers done");
        // Timer mode without prescaler, pause after write, wrap
        wreg(TIMER_CONFIG_OFS, 8'h08);
        chk_dir(4'h0);
        x = {6'h3f, 2'($random(seed))};
        wreg(TIMER_COUNT_OFS, x);
        rd8(TIMER_COUNT_OFS, a1);
        chk("inhibit", x, a1);
        repeat (6) @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a1);
        chk("inhibit_end", 8'h01, {7'h0, (a1 - x) <= 8'h01});
        repeat (18) @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a2);
        chk("timer_step", a1 + 8'h05, a2);
        $display("test timer done");
        // Clear the watchdog side before the prescaler moves back to the timer
        wd_pulse(1'b1, 1);
        // Every prescale ratio, two steps per measured span
        for (int r = 0; r < 8; r++) begin
            wreg(TIMER_CONFIG_OFS, 8'(r));
            wreg(TIMER_COUNT_OFS, 8'h00);
            repeat (20) @(posedge core_clk);
            rd8(TIMER_COUNT_OFS, a1);
            repeat ((16 << r) - 2) @(posedge core_clk);
            rd8(TIMER_COUNT_OFS, a2);
            chk("ratio_step", a1 + 8'h02, a2);
        end
        // Count write restarts the prescaler from zero
        repeat (400) @(posedge core_clk);
        wreg(TIMER_COUNT_OFS, 8'h00);
        repeat (398) @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a1);
        chk("presc_clear", 8'h00, a1);
        repeat (198) @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a1);
        chk("presc_clear", 8'h01, a1);
        $display("test prescaler done");
        // Counter mode, rising then falling edge, read two clocks after last fall
        for (int e = 0; e < 2; e++) begin
            wreg(TIMER_CONFIG_OFS, 8'h28 | 8'(e << 4));
            repeat (10) @(posedge core_clk);
            wreg(TIMER_COUNT_OFS, 8'h00);
            repeat (10) @(posedge core_clk);
            n = 3 + ($random(seed) & 3);
            burst(4'h6, n);
            repeat (12 * n - 5) @(posedge core_clk);
            rd8(TIMER_COUNT_OFS, a1);
            chk("edge_count", 8'(n - e), a1);
            repeat (12) @(posedge core_clk);
            rd8(TIMER_COUNT_OFS, a1);
            chk("edge_total", 8'(n), a1);
        end
        // Scaled counter mode, divide by two
        wreg(TIMER_CONFIG_OFS, 8'h20);
        repeat (10) @(posedge core_clk);
        wreg(TIMER_COUNT_OFS, 8'h00);
        repeat (10) @(posedge core_clk);
        burst(4'h2, 8);
        repeat (50) @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a1);
        chk("scaled_count", 8'h04, a1);
        $display("test counter done");
        // Watchdog side: no post on timer, 1:4 post, clears hold it off
        wreg(TIMER_CONFIG_OFS, 8'h00);
        p0 = n_post;
        repeat (8) wd_pulse(1'b0, 1 + ($random(seed) & 3));
        repeat (2) @(posedge core_clk);
        chk("post_timer", 8'h00, 8'(n_post - p0));
        wd_pulse(1'b1, 2);
        wreg(TIMER_COUNT_OFS, 8'h00);
        wreg(TIMER_CONFIG_OFS, 8'h0a);
        wd_pulse(1'b1, 2);
        p0 = n_post;
        repeat (8) wd_pulse(1'b0, 1 + ($random(seed) & 3));
        repeat (2) @(posedge core_clk);
        chk("post_wd", 8'h02, 8'(n_post - p0));
        p0 = n_post;
        repeat (4) begin
            wd_pulse(1'b0, 1);
            wd_pulse(1'b0, 1);
            wd_pulse(1'b1, 1);
        end
        repeat (2) @(posedge core_clk);
        chk("post_clear", 8'h00, 8'(n_post - p0));
        $display("test watchdog done");
        // Count survives a mid-run reset, read before any pin filter delay
        wreg(TIMER_COUNT_OFS, 8'h5a);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd8(TIMER_COUNT_OFS, a1);
        chk("count_kept", 8'h5a, a1);
        chk_dir(4'hf);
        $display("test reset done");
        report_and_stop;
    end
endmodule // tb
